// File: core/evbc_pkg.sv
// Shared constants and types of the encoder velocity and back-EMF compensation block.
// Assumes one system clock; register offsets are the device's register indices.
package evbc_pkg;

    // System clock rate in hertz.
    localparam int unsigned CLK_FREQ_HZ = 25_000_000;

    // Register indices on the internal register port.
    localparam logic [6:0] OFS_LOAD_ANGLE_MAX  = 7'h1c;
    localparam logic [6:0] OFS_EMF_VMIN        = 7'h60;
    localparam logic [6:0] OFS_EMF_SPAN        = 7'h61;
    localparam logic [6:0] OFS_IDLE_TIMEOUT    = 7'h62;
    localparam logic [6:0] OFS_FILTER_CFG      = 7'h63;
    localparam logic [6:0] OFS_VEL_RAW         = 7'h65;
    localparam logic [6:0] OFS_VEL_FILT        = 7'h66;
    localparam logic [6:0] OFS_EVENTS          = 7'h0e;

    // Field positions of the filter configuration register and of the idle event bit.
    localparam int unsigned WAIT_LSB   = 0;
    localparam int unsigned WAIT_W     = 8;
    localparam int unsigned EXP_LSB    = 8;
    localparam int unsigned EXP_W      = 4;
    localparam int unsigned PERIOD_LSB = 16;
    localparam int unsigned PERIOD_W   = 16;
    localparam int unsigned EVT_IDLE_BIT = 0;

    // Reset values.
    localparam logic [7:0]  LOAD_ANGLE_MAX_RST = 8'hff;
    localparam logic [31:0] EMF_VMIN_RST       = 32'h0000_0000;
    localparam logic [31:0] EMF_SPAN_RST       = 32'h0000_0000;
    localparam logic [31:0] IDLE_TIMEOUT_RST   = 32'h0000_0000;
    localparam logic [31:0] FILTER_CFG_RST     = 32'h0000_0000;

    // Least velocity update period with an incremental encoder.
    localparam logic [15:0] PERIOD_MIN_INCR = 16'h0100;

    // Width of the velocity and load-angle divider datapaths.
    localparam int unsigned DIV_W = 56;

    typedef enum logic [1:0] {
        EVBC_ENC_INCR = 2'h0,
        EVBC_ENC_SSI  = 2'h1,
        EVBC_ENC_RSVD = 2'h2,
        EVBC_ENC_SPI  = 2'h3
    } evbc_enc_type_t;

    typedef enum logic [1:0] {
        GS_IDLE = 2'b01,
        GS_DIV  = 2'b10
    } evbc_gamma_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [6:0]  addr;
        logic [31:0] wdata;
    } evbc_reg_req_t;

endpackage

// File: core/evbc_divider.sv
// Unsigned restoring divider, one quotient bit per clock.
// Assumes start is only raised while busy is low; division by zero gives all ones.
`timescale 1ns/10ps
module evbc_divider #(
    parameter int unsigned W = 56
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rst_i,
    // Request
    input  wire logic         start_i,
    input  wire logic [W-1:0] dividend_i,
    input  wire logic [W-1:0] divisor_i,
    // Answer
    output logic              busy_o,
    output logic              done_o,
    output logic [W-1:0]      quotient_o
);
    logic [W:0]           rem_q;
    logic [W-1:0]         den_q;
    logic [$clog2(W+1)-1:0] cnt_q;
    logic [W:0]           shifted;

    generate
        if (W < 2) begin : g_chk
            $error("evbc_divider: width too small");
        end
    endgenerate

    assign shifted = {rem_q[W-1:0], quotient_o[W-1]};

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rem_q      <= '0;
            den_q      <= '0;
            cnt_q      <= '0;
            quotient_o <= '0;
            busy_o     <= 1'b0;
            done_o     <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin
                rem_q      <= '0;
                den_q      <= divisor_i;
                quotient_o <= dividend_i;
                cnt_q      <= ($clog2(W+1))'(W);
                busy_o     <= 1'b1;
            end else if (busy_o) begin
                if (shifted >= {1'b0, den_q}) begin
                    rem_q      <= shifted - {1'b0, den_q};
                    quotient_o <= {quotient_o[W-2:0], 1'b1};
                end else begin
                    rem_q      <= shifted;
                    quotient_o <= {quotient_o[W-2:0], 1'b0};
                end
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == 1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
endmodule // evbc_divider

// File: core/evbc_backemf_comp.sv
// Encoder velocity measurement, exponential filter, idle detection and back-EMF
// load-angle compensation of the commutation angle.
// Assumes register accesses arrive on the internal register port in the system clock
// domain; quadrature pins are asynchronous; absolute positions come on the same clock.
//
// Summary of operation
// - Enabled compensation adds offset in motion direction.
// - Offset zero, linear ramp, then clamped maximum.
// - Maximum load angle resets to 255.
// - Compensation active only while enable bit set.
// - Thresholds compare against filtered encoder velocity.
// - Raw encoder velocity readable, microsteps per second.
// - Filtered encoder velocity readable, microsteps per second.
// - Filter: mean minus shifted mean plus shifted raw.
// - Filter samples spaced by sample-wait plus one clock cycles.
// - Incremental update period forced to at least 256.
// - Absolute encoder update period follows request period.
// - Low velocities computed on quadrature transitions.
// - No transition for timeout cycles raises idle event.
// - Two-bit field selects encoder input type.
`timescale 1ns/10ps
module evbc_backemf_comp #(
    parameter int unsigned CLK_HZ  = evbc_pkg::CLK_FREQ_HZ,
    parameter int unsigned ANGLE_W = 10
) (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  rst_i,
    // Register port
    input  evbc_pkg::evbc_reg_req_t    reg_req_i,
    output logic [31:0]                reg_rdata_o,
    // Encoder pins and absolute encoder position
    input  wire logic                  enc_a_i,
    input  wire logic                  enc_b_i,
    input  wire logic [31:0]           abs_pos_i,
    input  wire logic                  abs_pos_valid_i,
    // Configuration from the rest of the device
    input  evbc_pkg::evbc_enc_type_t   enc_type_i,
    input  wire logic                  back_emf_comp_enable_i,
    input  wire logic [31:0]           serial_request_period_i,
    // Commutation angle
    input  wire logic [ANGLE_W-1:0]    commutation_angle_i,
    output logic [ANGLE_W-1:0]         comp_angle_o,
    output logic [7:0]                 load_angle_o,
    // Events
    output logic                       encoder_idle_event_o
);
    localparam int unsigned DW = evbc_pkg::DIV_W;

    generate
        if (ANGLE_W < 9 || CLK_HZ == 0 || CLK_HZ > 32'h00ff_ffff * 2) begin : g_chk
            $error("evbc_backemf_comp: unsupported parameters");
        end
    endgenerate

    // Registers.
    logic [7:0]  load_angle_max_q;
    logic [31:0] emf_velocity_min_q;
    logic [31:0] emf_velocity_span_q;
    logic [31:0] encoder_idle_timeout_q;
    logic [31:0] velocity_filter_config_q;
    logic signed [31:0] vel_raw_q;
    logic signed [31:0] vel_filt_q;

    // Quadrature synchroniser and decoder state.
    logic a_s1_q, a_s2_q, a_q;
    logic b_s1_q, b_s2_q, b_q;
    logic [31:0] pos_q;
    logic [31:0] pos_ref_q;
    logic [31:0] since_q;
    logic [31:0] per_cnt_q;
    logic [7:0]  smp_cnt_q;

    logic        incr;
    logic        quad_step;
    logic        quad_up;
    logic        move;
    logic [31:0] eff_period;
    logic [15:0] period_field;
    logic [7:0]  sample_wait;
    logic [3:0]  filt_exp;
    logic        period_end;
    logic signed [31:0] delta;
    logic [31:0] delta_mag;
    logic [23:0] delta_sat;
    logic [31:0] since_next;
    logic        idle_hit;

    assign incr         = (enc_type_i == evbc_pkg::EVBC_ENC_INCR);
    assign period_field = velocity_filter_config_q[evbc_pkg::PERIOD_LSB +: evbc_pkg::PERIOD_W];
    assign filt_exp     = velocity_filter_config_q[evbc_pkg::EXP_LSB +: evbc_pkg::EXP_W];

    // Update period: clamped for incremental, taken from the request rate otherwise.
    always_comb begin
        if (incr) begin
            eff_period = {16'h0000, (period_field < evbc_pkg::PERIOD_MIN_INCR) ?
                          evbc_pkg::PERIOD_MIN_INCR : period_field};
        end else begin
            eff_period = (serial_request_period_i == 32'h0) ? 32'h1 :
                         serial_request_period_i;
        end
    end

    always_comb begin
        if (incr) begin
            sample_wait = velocity_filter_config_q[evbc_pkg::WAIT_LSB +: evbc_pkg::WAIT_W];
        end else begin
            sample_wait = (serial_request_period_i > 32'h0000_00ff) ? 8'hff :
                          serial_request_period_i[7:0];
        end
    end

    assign quad_step  = (a_s2_q ^ a_q) | (b_s2_q ^ b_q);
    assign quad_up    = a_q ^ b_s2_q;
    assign move       = incr ? quad_step : (abs_pos_valid_i && (abs_pos_i != pos_q));
    assign period_end = (per_cnt_q >= eff_period - 32'h1);
    assign delta      = $signed(pos_q - pos_ref_q);
    assign delta_mag  = delta[31] ? 32'(-delta) : 32'(delta);
    assign delta_sat  = (delta_mag > 32'h00ff_ffff) ? 24'hff_ffff : delta_mag[23:0];
    assign since_next = (since_q == 32'hffff_ffff) ? since_q : since_q + 32'h1;
    assign idle_hit   = (encoder_idle_timeout_q != 32'h0) &&
                        (since_next == encoder_idle_timeout_q) && !move;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            a_q    <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            b_q    <= 1'b0;
        end else begin
            a_s1_q <= enc_a_i;
            a_s2_q <= a_s1_q;
            a_q    <= a_s2_q;
            b_s1_q <= enc_b_i;
            b_s2_q <= b_s1_q;
            b_q    <= b_s2_q;
        end
    end

    // Position follows quadrature steps or the absolute encoder value.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pos_q <= 32'h0;
        end else if (incr) begin
            if (quad_step) begin
                pos_q <= quad_up ? pos_q + 32'h1 : pos_q - 32'h1;
            end
        end else if (abs_pos_valid_i) begin
            pos_q <= abs_pos_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            since_q   <= 32'h0;
            per_cnt_q <= 32'h0;
            pos_ref_q <= 32'h0;
        end else begin
            since_q <= move ? 32'h0 : since_next;
            if (period_end) begin
                per_cnt_q <= 32'h0;
                pos_ref_q <= pos_q;
            end else begin
                per_cnt_q <= per_cnt_q + 32'h1;
            end
        end
    end

    // Velocity division requests: counted steps per period, or one step per interval.
    logic          fast_req;
    logic          slow_req;
    logic          vdiv_start;
    logic [DW-1:0] vdiv_dividend;
    logic [DW-1:0] vdiv_divisor;
    logic          vdiv_busy;
    logic          vdiv_done;
    logic [DW-1:0] vdiv_quot;
    logic          vneg_q;
    logic [31:0]   vmag;

    assign fast_req   = period_end && (!incr || delta_mag >= 32'h2);
    assign slow_req   = incr && quad_step && (since_next >= eff_period);
    assign vdiv_start = (fast_req || slow_req) && !vdiv_busy;

    always_comb begin
        if (fast_req) begin
            vdiv_dividend = DW'({32'h0, delta_sat}) * DW'(CLK_HZ);
            vdiv_divisor  = DW'(eff_period);
        end else begin
            vdiv_dividend = DW'(CLK_HZ);
            vdiv_divisor  = DW'(since_next);
        end
    end

    evbc_divider #(
        .W(DW)
    ) u_vel_div (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .start_i    (vdiv_start),
        .dividend_i (vdiv_dividend),
        .divisor_i  (vdiv_divisor),
        .busy_o     (vdiv_busy),
        .done_o     (vdiv_done),
        .quotient_o (vdiv_quot)
    );

    assign vmag = (vdiv_quot > DW'(32'h7fff_ffff)) ? 32'h7fff_ffff : vdiv_quot[31:0];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            vneg_q    <= 1'b0;
            vel_raw_q <= 32'sh0;
        end else begin
            if (vdiv_start) begin
                vneg_q <= fast_req ? delta[31] : !quad_up;
            end
            if (idle_hit) begin
                vel_raw_q <= 32'sh0;
            end else if (vdiv_done) begin
                vel_raw_q <= vneg_q ? -$signed(vmag) : $signed(vmag);
            end
        end
    end

    // Exponential filter, one sample every sample-wait plus one cycles.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_cnt_q  <= 8'h0;
            vel_filt_q <= 32'sh0;
        end else if (smp_cnt_q >= sample_wait) begin
            smp_cnt_q  <= 8'h0;
            vel_filt_q <= vel_filt_q - (vel_filt_q >>> filt_exp)
                          + (vel_raw_q >>> filt_exp);
        end else begin
            smp_cnt_q <= smp_cnt_q + 8'h1;
        end
    end

    // Load angle from the filtered velocity magnitude.
    evbc_pkg::evbc_gamma_state_t gstate_q;
    logic [31:0]   filt_mag;
    logic [31:0]   over_min;
    logic          gdiv_start;
    logic [DW-1:0] gdiv_quot;
    logic          gdiv_busy;
    logic          gdiv_done;
    logic [7:0]    gamma_q;

    assign filt_mag   = vel_filt_q[31] ? 32'(-vel_filt_q) : 32'(vel_filt_q);
    assign over_min   = filt_mag - emf_velocity_min_q;
    assign gdiv_start = (gstate_q == evbc_pkg::GS_IDLE) && (filt_mag > emf_velocity_min_q)
                        && (over_min <= emf_velocity_span_q) && (emf_velocity_span_q != 32'h0);

    evbc_divider #(
        .W(DW)
    ) u_gamma_div (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .start_i    (gdiv_start),
        .dividend_i (DW'(over_min) * DW'(load_angle_max_q)),
        .divisor_i  (DW'(emf_velocity_span_q)),
        .busy_o     (gdiv_busy),
        .done_o     (gdiv_done),
        .quotient_o (gdiv_quot)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            gstate_q <= evbc_pkg::GS_IDLE;
            gamma_q  <= 8'h0;
        end else begin
            unique case (gstate_q)
                evbc_pkg::GS_IDLE: begin
                    if (filt_mag <= emf_velocity_min_q) begin
                        gamma_q <= 8'h0;
                    end else if (gdiv_start) begin
                        gstate_q <= evbc_pkg::GS_DIV;
                    end else begin
                        gamma_q <= load_angle_max_q;
                    end
                end
                evbc_pkg::GS_DIV: begin
                    if (gdiv_done) begin
                        gamma_q  <= gdiv_quot[7:0];
                        gstate_q <= evbc_pkg::GS_IDLE;
                    end
                end
                default: begin
                    gstate_q <= evbc_pkg::GS_IDLE;
                end
            endcase
        end
    end

    // Compensated commutation angle.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            comp_angle_o <= '0;
            load_angle_o <= 8'h0;
        end else if (back_emf_comp_enable_i) begin
            load_angle_o <= gamma_q;
            comp_angle_o <= vel_filt_q[31] ?
                            commutation_angle_i - ANGLE_W'(gamma_q) :
                            commutation_angle_i + ANGLE_W'(gamma_q);
        end else begin
            load_angle_o <= 8'h0;
            comp_angle_o <= commutation_angle_i;
        end
    end

    // Register writes, sticky idle event and read data.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            load_angle_max_q         <= evbc_pkg::LOAD_ANGLE_MAX_RST;
            emf_velocity_min_q       <= evbc_pkg::EMF_VMIN_RST;
            emf_velocity_span_q      <= evbc_pkg::EMF_SPAN_RST;
            encoder_idle_timeout_q   <= evbc_pkg::IDLE_TIMEOUT_RST;
            velocity_filter_config_q <= evbc_pkg::FILTER_CFG_RST;
        end else if (reg_req_i.wr) begin
            unique case (reg_req_i.addr)
                evbc_pkg::OFS_LOAD_ANGLE_MAX: load_angle_max_q <= reg_req_i.wdata[7:0];
                evbc_pkg::OFS_EMF_VMIN:       emf_velocity_min_q <= reg_req_i.wdata;
                evbc_pkg::OFS_EMF_SPAN:       emf_velocity_span_q <= reg_req_i.wdata;
                evbc_pkg::OFS_IDLE_TIMEOUT:   encoder_idle_timeout_q <= reg_req_i.wdata;
                evbc_pkg::OFS_FILTER_CFG:     velocity_filter_config_q <= reg_req_i.wdata;
                default: ;
            endcase
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            encoder_idle_event_o <= 1'b0;
        end else if (idle_hit) begin
            encoder_idle_event_o <= 1'b1;
        end else if (reg_req_i.wr && reg_req_i.addr == evbc_pkg::OFS_EVENTS &&
                     reg_req_i.wdata[evbc_pkg::EVT_IDLE_BIT]) begin
            encoder_idle_event_o <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0;
        end else if (reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                evbc_pkg::OFS_LOAD_ANGLE_MAX: reg_rdata_o <= {24'h0, load_angle_max_q};
                evbc_pkg::OFS_EMF_VMIN:       reg_rdata_o <= emf_velocity_min_q;
                evbc_pkg::OFS_EMF_SPAN:       reg_rdata_o <= emf_velocity_span_q;
                evbc_pkg::OFS_IDLE_TIMEOUT:   reg_rdata_o <= encoder_idle_timeout_q;
                evbc_pkg::OFS_FILTER_CFG:     reg_rdata_o <= velocity_filter_config_q;
                evbc_pkg::OFS_VEL_RAW:        reg_rdata_o <= vel_raw_q;
                evbc_pkg::OFS_VEL_FILT:       reg_rdata_o <= vel_filt_q;
                evbc_pkg::OFS_EVENTS:         reg_rdata_o <= {31'h0, encoder_idle_event_o};
                default:                      reg_rdata_o <= 32'h0;
            endcase
        end
    end
endmodule // evbc_backemf_comp

// File: verification/evbc_backemf_comp_chk.sv
// Port-level checker of the back-EMF compensation block.
// Assumes one clock domain and the register port contract of the block.
`timescale 1ns/10ps
module evbc_backemf_comp_chk #(
    parameter int unsigned ANGLE_W = 10
) (
    // Clock and reset
    input wire logic                  mclk_i,
    input wire logic                  rst_i,
    // Register port
    input evbc_pkg::evbc_reg_req_t    reg_req_i,
    input wire logic [31:0]           reg_rdata_o,
    // Encoder and angle
    input wire logic                  enc_a_i,
    input wire logic                  enc_b_i,
    input wire logic                  back_emf_comp_enable_i,
    input wire logic [ANGLE_W-1:0]    commutation_angle_i,
    input wire logic [ANGLE_W-1:0]    comp_angle_o,
    input wire logic [7:0]            load_angle_o,
    input wire logic                  encoder_idle_event_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic [7:0]  max_q;
    logic [31:0] tmo_q;
    logic [31:0] quiet_q;
    logic        a_q;
    logic        b_q;
    logic        clr;
    assign clr = reg_req_i.wr && reg_req_i.addr == evbc_pkg::OFS_EVENTS && reg_req_i.wdata[0];
    // Shadows of the maximum and the timeout, taken from the writes seen on the port.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            max_q <= 8'hff;
            tmo_q <= 32'h0;
        end else if (reg_req_i.wr) begin
            if (reg_req_i.addr == evbc_pkg::OFS_LOAD_ANGLE_MAX) max_q <= reg_req_i.wdata[7:0];
            if (reg_req_i.addr == evbc_pkg::OFS_IDLE_TIMEOUT) tmo_q <= reg_req_i.wdata;
        end
    end
    // Cycles since the quadrature pins last changed.
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            quiet_q <= 32'h0;
        end else begin
            a_q <= enc_a_i;
            b_q <= enc_b_i;
            if (a_q != enc_a_i || b_q != enc_b_i) quiet_q <= 32'h0;
            else if (quiet_q != 32'hffff_ffff) quiet_q <= quiet_q + 32'h1;
        end
    end
    a_idle_sticky: assert property (
        encoder_idle_event_o && !clr |=> encoder_idle_event_o)
        else $error("idle flag dropped without a clear");
    a_idle_quiet: assert property (
        $rose(encoder_idle_event_o) |-> tmo_q != 32'h0 && quiet_q >= tmo_q)
        else $error("idle flag raised before the timeout");
    a_off_bypass: assert property (
        !$past(rst_i) && !$past(back_emf_comp_enable_i) |->
        comp_angle_o == $past(commutation_angle_i) && load_angle_o == 8'h0)
        else $error("angle altered while compensation is off");
    a_on_direction: assert property (
        !$past(rst_i) && $past(back_emf_comp_enable_i) |->
        comp_angle_o == $past(commutation_angle_i) + ANGLE_W'(load_angle_o) ||
        comp_angle_o == $past(commutation_angle_i) - ANGLE_W'(load_angle_o))
        else $error("offset not added to the angle");
    a_gamma_bound: assert property (
        load_angle_o <= max_q)
        else $error("offset above the maximum");
    a_max_readback: assert property (
        reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == evbc_pkg::OFS_LOAD_ANGLE_MAX
        |=> reg_rdata_o == {24'h0, max_q})
        else $error("maximum read back wrong");
    a_unmapped_zero: assert property (
        reg_req_i.rd && reg_req_i.addr == 7'h7f |=> reg_rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !reg_req_i.rd |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");
endmodule // evbc_backemf_comp_chk
bind evbc_backemf_comp evbc_backemf_comp_chk #(.ANGLE_W(ANGLE_W)) evbc_backemf_comp_chk_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
    .enc_a_i(enc_a_i), .enc_b_i(enc_b_i), .back_emf_comp_enable_i(back_emf_comp_enable_i),
    .commutation_angle_i(commutation_angle_i), .comp_angle_o(comp_angle_o),
    .load_angle_o(load_angle_o), .encoder_idle_event_o(encoder_idle_event_o));

// File: verification/evbc_enc_model.sv
// Encoder model: quadrature steps and absolute positions at a fixed spacing.
// Assumes the bench sets run and spacing; positions advance by four per step.
`timescale 1ns/10ps
module evbc_enc_model (
    // Clock, reset and control
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic [15:0] gap_i,
    // Encoder outputs
    output logic             enc_a_o,
    output logic             enc_b_o,
    output logic [31:0]      abs_pos_o,
    output logic             abs_pos_valid_o
);
    logic [15:0] cnt_q;
    logic [1:0]  ph_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0;
            ph_q <= 2'h0;
            abs_pos_o <= 32'h0;
            abs_pos_valid_o <= 1'b0;
        end else begin
            abs_pos_valid_o <= 1'b0;
            if (run_i) begin
                cnt_q <= cnt_q + 16'h1;
                if (cnt_q >= gap_i - 16'h1) begin
                    cnt_q <= 16'h0;
                    ph_q <= ph_q + 2'h1;
                    abs_pos_o <= abs_pos_o + 32'h4;
                    abs_pos_valid_o <= 1'b1;
                end
            end
        end
    end
    // Gray order so that only one pin changes per step.
    assign enc_a_o = ph_q[1];
    assign enc_b_o = ph_q[1] ^ ph_q[0];
endmodule // evbc_enc_model

// File: verification/evbc_backemf_comp_test.sv
// Self-checking bench of the back-EMF compensation block with an encoder model.
// Assumes the 25 MHz clock and the register port contract of the block.
`timescale 1ns/10ps
module evbc_backemf_comp_test;
    logic                    mclk_i = 1'b0;
    logic                    rst_i = 1'b1;
    evbc_pkg::evbc_reg_req_t req = '0;
    evbc_pkg::evbc_enc_type_t etype = evbc_pkg::EVBC_ENC_INCR;
    logic                    en = 1'b0;
    logic                    run = 1'b0;
    logic [15:0]             gap = 16'h3e8;
    logic [9:0]              ang = 10'h0;
    logic [31:0]             rdata, d, v, vmin, span;
    logic [7:0]              g;
    logic [9:0]              comp;
    logic [7:0]              load;
    logic                    idle, ea, eb, pv;
    logic [31:0]             pos;
    int                      fail_count = 0;
    int                      check_count = 0;
    int                      cyc = 0;
    integer                  seed = 66806;
    always #20 mclk_i = ~mclk_i;
    evbc_backemf_comp evbc_backemf_comp_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_req_i(req), .reg_rdata_o(rdata),
        .enc_a_i(ea), .enc_b_i(eb), .abs_pos_i(pos), .abs_pos_valid_i(pv),
        .enc_type_i(etype), .back_emf_comp_enable_i(en),
        .serial_request_period_i({16'h0, gap}), .commutation_angle_i(ang),
        .comp_angle_o(comp), .load_angle_o(load), .encoder_idle_event_o(idle));
    evbc_enc_model evbc_enc_model_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .run_i(run), .gap_i(gap),
        .enc_a_o(ea), .enc_b_o(eb), .abs_pos_o(pos), .abs_pos_valid_o(pv));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [31:0] w);
        @(negedge mclk_i) req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: w};
        @(negedge mclk_i) req = '0;
    endtask
    task automatic rd(input logic [6:0] a, output logic [31:0] r);
        @(negedge mclk_i) req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge mclk_i) r = rdata;
        req = '0;
    endtask
    function automatic logic [31:0] mag(input logic [31:0] x);
        return x[31] ? -x : x;
    endfunction
    function automatic logic [7:0] g_exp(input logic [31:0] a, lo, sp);
        logic [31:0] dd;
        dd = a - lo;
        if (a <= lo) return 8'h0;
        if (sp == 32'h0 || dd > sp) return 8'hc8;
        return 8'((64'(dd) * 64'hc8) / 64'(sp));
    endfunction
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(negedge mclk_i);
        rst_i = 1'b0;
        rd(7'h1c, d); cmp(d, 32'hff);
        rd(7'h7f, d); cmp(d, 32'h0);
        wr(7'h65, 32'h1234); rd(7'h65, d); cmp(d, 32'h0);
        wr(7'h1c, 32'hc8);
        wr(7'h63, 32'h28); rd(7'h63, d); cmp(d, 32'h28);
        run = 1'b1;
        repeat (5000) @(negedge mclk_i);
        rd(7'h65, v); cmp(mag(v), 32'h61a8);
        rd(7'h66, d); cmp(d, v);
        en = 1'b1;
        for (int i = 0; i < 6; i++) begin
            vmin = (i == 0) ? mag(v) : {$random(seed)} % 32'h7530;
            span = (i == 1) ? 32'h0 : {$random(seed)} % 32'h4e20;
            ang = 10'($random(seed));
            wr(7'h60, vmin);
            wr(7'h61, span);
            repeat (150) @(negedge mclk_i);
            g = g_exp(mag(v), vmin, span);
            cmp({24'h0, load}, {24'h0, g});
            cmp({22'h0, comp}, {22'h0, v[31] ? ang - 10'(g) : ang + 10'(g)});
        end
        en = 1'b0;
        repeat (2) @(negedge mclk_i);
        cmp({24'h0, load}, 32'h0);
        cmp({22'h0, comp}, {22'h0, ang});
        wr(7'h62, 32'h7d0);
        run = 1'b0;
        repeat (2500) @(negedge mclk_i);
        cmp({31'h0, idle}, 32'h1);
        rd(7'h65, d); cmp(d, 32'h0);
        rd(7'h0e, d); cmp(d & 32'h1, 32'h1);
        wr(7'h0e, 32'h1);
        cmp({31'h0, idle}, 32'h0);
        wr(7'h62, 32'h0);
        run = 1'b1;
        for (int t = 1; t < 4; t++) begin
            etype = evbc_pkg::evbc_enc_type_t'(t);
            gap = 16'h3e8 >> (t - 1);
            repeat (5000) @(negedge mclk_i);
            rd(7'h65, d); cmp(mag(d), 32'h5f5e100 / gap);
            rd(7'h66, d); cmp(mag(d), 32'h5f5e100 / gap);
        end
        tally_and_finish();
    end
endmodule // evbc_backemf_comp_test
